// ==== pcb_cal.v ====
// per-channel self calibration: compares reference readings and trims gain and offset
`timescale 1ns/1ns
`default_nettype none
`include "pcb_defs.vh"
module pcb_cal #(
  parameter NCH = 4,
  parameter CW = 2
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // reading from the input filter unit
  input wire rd_valid,
  input wire [CW-1:0] rd_ch,
  input wire rd_hi,
  input wire [15:0] rd_data,
  // stored references
  input wire [15:0] ref_hi,
  input wire [15:0] ref_lo,
  // coefficient readback
  input wire [CW-1:0] coef_sel,
  output reg [31:0] coef_q
);
  reg [15:0] gain_ff [0:NCH-1];
  reg [15:0] ofs_ff [0:NCH-1];
  wire [15:0] ref_w;
  assign ref_w = rd_hi ? ref_hi : ref_lo;
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          gain_ff[i] <= `PCB_RST_COEF_GAIN;
          ofs_ff[i] <= `PCB_RST_COEF_OFS;
        end else if (rd_valid && {{(32-CW){1'b0}}, rd_ch} == i && rd_data != ref_w) begin
          // high reading trims gain, low reading trims offset, one lsb a time [R10]
          if (rd_hi) begin
            gain_ff[i] <= (rd_data > ref_w) ? gain_ff[i] - 16'h0001 : gain_ff[i] + 16'h0001;
          end else begin
            ofs_ff[i] <= (rd_data > ref_w) ? ofs_ff[i] - 16'h0001 : ofs_ff[i] + 16'h0001;
          end
        end
      end
    end
  endgenerate
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      coef_q <= 32'h0000_0000;
    end else begin
      coef_q <= {gain_ff[coef_sel], ofs_ff[coef_sel]};
    end
  end
endmodule // pcb_cal
`default_nettype wire

// ==== pcb_checker.sv ====
// assertions for the channel set control block
`timescale 1ns/1ns
`default_nettype none
module pcb_checker #(parameter NCH = 4) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // plant
  input wire logic [NCH-1:0] cmp_trip_in,
  input wire logic test_unit_attached,
  input wire logic power_ok,
  input wire logic diag_fatal,
  input wire logic diag_nonfatal,
  input wire logic [NCH-1:0] panel_light,
  input wire logic bypass_ind,
  input wire logic set_fail_contact,
  input wire logic trouble_contact,
  input wire logic [15:0] aout,
  input wire logic inject_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_APB_READY: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  AST_APB_UNMAPPED: assert property (psel && penable && paddr > 12'h030 |-> pslverr)
    else $error("no error on unmapped access");
  AST_PWR_AOUT: assert property ((!power_ok)[*5] |-> aout == 16'h0000)
    else $error("aout not low on power loss");
  AST_FATAL_HOLD: assert property ((diag_fatal && power_ok)[*5] |-> $stable(aout))
    else $error("aout moved under fatal");
  AST_FAIL_CONTACT: assert property ((diag_fatal || diag_nonfatal)[*5] |-> set_fail_contact)
    else $error("failure contact idle");
  AST_TROUBLE: assert property ((diag_nonfatal && !diag_fatal && power_ok)[*5] |-> trouble_contact)
    else $error("trouble contact idle");
  // a bypassed comparator has its trip path disabled, so its light stays dark
  AST_LIGHT: assert property ((power_ok && !diag_fatal && $stable(cmp_trip_in))[*5]
    |-> bypass_ind || (cmp_trip_in & ~panel_light) == '0)
    else $error("tripped comparator light dark");
  AST_DETACH: assert property ((!test_unit_attached)[*5] |-> !bypass_ind && !inject_en)
    else $error("bypass left after detach");
  AST_BYP_ATTACHED: assert property ($rose(bypass_ind) |-> test_unit_attached)
    else $error("bypass without test unit");
  cover property ($rose(inject_en));
  cover property ($rose(bypass_ind));
  cover property ((!power_ok)[*5]);
endmodule // pcb_checker
bind pcb_top pcb_checker #(.NCH(NCH)) pcb_checker_i (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .cmp_trip_in(cmp_trip_in),
  .test_unit_attached(test_unit_attached), .power_ok(power_ok), .diag_fatal(diag_fatal),
  .diag_nonfatal(diag_nonfatal), .panel_light(panel_light), .bypass_ind(bypass_ind),
  .set_fail_contact(set_fail_contact), .trouble_contact(trouble_contact), .aout(aout),
  .inject_en(inject_en));
`default_nettype wire

// ==== pcb_defs.vh ====
// shared offsets, field positions, reset values and step time for the channel set control block
`ifndef PCB_DEFS_VH
`define PCB_DEFS_VH
// register byte offsets
`define PCB_OFF_CTRL 12'h000
`define PCB_OFF_TEST 12'h004
`define PCB_OFF_STEP 12'h008
`define PCB_OFF_CMP 12'h00c
`define PCB_OFF_STAT 12'h010
`define PCB_OFF_DIAG 12'h014
`define PCB_OFF_PWD 12'h018
`define PCB_OFF_FAIL 12'h01c
`define PCB_OFF_AOUT 12'h020
`define PCB_OFF_CAL 12'h024
`define PCB_OFF_REFH 12'h028
`define PCB_OFF_REFL 12'h02c
`define PCB_OFF_COEF 12'h030
// test command codes written to TEST[3:0]
`define PCB_CMD_NONE 4'h0
`define PCB_CMD_SEL 4'h1
`define PCB_CMD_MODE 4'h2
`define PCB_CMD_TRIP 4'h3
`define PCB_CMD_BYP 4'h4
`define PCB_CMD_CALREF 4'h5
`define PCB_CMD_TBASE 4'h6
`define PCB_CMD_SUBT 4'h7
`define PCB_CMD_INJ 4'h8
`define PCB_CMD_ABORT 4'hf
// TEST field positions
`define PCB_TEST_CMD_LSB 0
`define PCB_TEST_CH_LSB 8
`define PCB_TEST_AUTO_BIT 16
// reset values
`define PCB_RST_PWD 32'h0000_0000
`define PCB_RST_FAIL 32'h0000_0000
`define PCB_RST_COEF_GAIN 16'h4000
`define PCB_RST_COEF_OFS 16'h0000
`define PCB_RST_REFH 16'hc000
`define PCB_RST_REFL 16'h4000
// a tester step whose subtest is enabled holds this many nanoseconds unless the step done input arrives earlier
`define PCB_STEP_TIME_NS 1000
`endif

// ==== pcb_partner.sv ====
// far side model: tester step answers and reference readings
`timescale 1ns/1ns
`default_nettype none
module pcb_partner (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // from the block
  input wire logic [2:0] tester_step,
  input wire logic [3:0] mux_sel_ref,
  input wire logic [3:0] mux_ref_hi,
  // answer speed
  input wire logic slow,
  // to the block
  output logic step_done,
  output logic rd_valid,
  output logic [1:0] rd_ch,
  output logic rd_hi,
  output logic [15:0] rd_data
);
  int cnt;
  logic [2:0] last_step;
  logic [2:0] rc;
  // each step other than step 0 answered after a short or a long delay
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      last_step <= 3'h0;
      step_done <= 1'b0;
    end else if (tester_step != last_step) begin
      last_step <= tester_step;
      cnt <= 0;
      step_done <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      // one-cycle pulse, so a done never spills into the following step
      step_done <= tester_step != 3'h0 && cnt == (slow ? 30 : 4);
    end
  end
  // readings of the selected reference, with a small error, data scrambled between them
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rc <= 3'h0;
      rd_valid <= 1'b0;
      rd_ch <= 2'h0;
      rd_hi <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      rc <= rc + 3'h1;
      rd_valid <= rc == 3'h7 && mux_sel_ref[0];
      rd_hi <= mux_ref_hi[0];
      rd_data <= (rc == 3'h7) ? (mux_ref_hi[0] ? 16'hc010 : 16'h4010) : ~rd_data;
    end
  end
endmodule // pcb_partner
`default_nettype wire

// ==== pcb_sync.v ====
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ns
`default_nettype none
module pcb_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // data
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end
  assign q = sync_ff;
endmodule // pcb_sync
`default_nettype wire

// ==== pcb_top.v ====
// protection channel set control: test sequence, bypass, forced trip, failure modes
//
// How it works
// R1: bypassed channel has trip path disabled, relay held non-tripped.
// R2: forced-trip channel breaks comparator output, relay de-energised.
// R3: tested channel must be in trip or bypass; bypass needs valid password.
// R4: start order: channel, mode, trip/bypass, calibrate, time base, subtests, inject.
// R5: after injection: converter, deviation, partial trip, response, loop cycle steps.
// R6: at cycle end clear trip/bypass, re-verify injection calibration, report.
// R7: interrupted comparator output trips logic and raises alarm and status.
// R8: one panel light per comparator, lit while tripped.
// R9: calibration selects high/low reference through per-channel input mux.
// R10: reference errors trim that channel's gain and offset.
// R11: one channel may stay bypassed and tested without system action.
// R12: bypass indication stays on while any channel is bypassed.
// R13: detaching the operator test unit clears bypass.
// R14: power loss: comparators to preferred state, analog outputs below low scale.
// R15: fatal diagnostic forces comparators to preferred failure state.
// R16: fatal diagnostic freezes analog outputs.
// R17: one channel set failure contact, actuated on any diagnostic.
// R18: non-fatal diagnostic only drives trouble and failure contacts.
// R19: after reset no bypass or forced trip; sequence idle.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "pcb_defs.vh"
module pcb_top #(
  parameter NCH = 4,
  parameter CW = 2,
  parameter CLK_MHZ = 20
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // plant pins
  input wire [NCH-1:0] cmp_trip_in,
  input wire test_unit_attached,
  input wire power_ok,
  input wire diag_fatal,
  input wire diag_nonfatal,
  input wire step_done,
  // input filter unit reference readings
  input wire rd_valid,
  input wire [CW-1:0] rd_ch,
  input wire rd_hi,
  input wire [15:0] rd_data,
  // analog output source
  input wire [15:0] aout_in,
  // outputs to plant
  output reg [NCH-1:0] relay_energised,
  output reg [NCH-1:0] panel_light,
  output reg chan_trip_alarm,
  output reg chan_status,
  output reg bypass_ind,
  output reg set_fail_contact,
  output reg trouble_contact,
  output reg [15:0] aout,
  output reg [NCH-1:0] mux_sel_ref,
  output reg [NCH-1:0] mux_ref_hi,
  output reg inject_en,
  output reg [2:0] tester_step
);
  localparam [3:0] S_IDLE = 4'd0, S_CHSEL = 4'd1, S_MODE = 4'd2, S_TRBY = 4'd3, S_CALREF = 4'd4,
    S_TBASE = 4'd5, S_SUBT = 4'd6, S_RUN = 4'd7, S_VERIFY = 4'd8, S_REPORT = 4'd9;
  localparam integer STEP_CYC_I = (`PCB_STEP_TIME_NS * CLK_MHZ) / 1000;
  localparam [15:0] STEP_CYC = STEP_CYC_I[15:0];
  localparam [31:0] RST_FAIL = `PCB_RST_FAIL;
  localparam [2:0] LAST_STEP = 3'd4;
  localparam [15:0] AOUT_LOW = 16'h0000;
  // synchronised pins
  wire [NCH-1:0] cmp_s;
  wire [4:0] pin_s;
  pcb_sync #(.W(NCH)) u_sync_cmp (.clk(clk), .rst(rst), .d(cmp_trip_in), .q(cmp_s));
  pcb_sync #(.W(5)) u_sync_pin (.clk(clk), .rst(rst),
    .d({test_unit_attached, power_ok, diag_fatal, diag_nonfatal, step_done}), .q(pin_s));
  wire attached_s = pin_s[4];
  wire power_s = pin_s[3];
  wire fatal_s = pin_s[2];
  wire nonfatal_s = pin_s[1];
  wire done_s = pin_s[0];
  // registers
  reg [3:0] state_ff;
  reg [CW-1:0] ch_ff;
  reg auto_ff;
  reg [NCH-1:0] byp_ff;
  reg [NCH-1:0] ftrip_ff;
  reg [7:0] subt_ff;
  reg [2:0] step_ff;
  reg [15:0] cnt_ff;
  reg [31:0] pwd_ff;
  reg [NCH-1:0] fail_pref_ff;
  reg [15:0] refh_ff;
  reg [15:0] refl_ff;
  reg [CW-1:0] coef_sel_ff;
  reg [NCH-1:0] cal_en_ff;
  reg cal_hi_ff;
  reg [7:0] results_ff;
  reg seq_err_ff;
  reg fatal_seen_ff;
  reg nonfatal_seen_ff;
  wire [31:0] coef_q;
  pcb_cal #(.NCH(NCH), .CW(CW)) u_cal (.clk(clk), .rst(rst), .rd_valid(rd_valid), .rd_ch(rd_ch),
    .rd_hi(rd_hi), .rd_data(rd_data), .ref_hi(refh_ff), .ref_lo(refl_ff), .coef_sel(coef_sel_ff),
    .coef_q(coef_q));
  // apb decode
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire mapped = (paddr <= `PCB_OFF_COEF) && (paddr[1:0] == 2'b00);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  wire test_wr = wr && paddr == `PCB_OFF_TEST;
  wire [3:0] cmd = pwdata[`PCB_TEST_CMD_LSB +: 4];
  wire [CW-1:0] cmd_ch = pwdata[`PCB_TEST_CH_LSB +: CW];
  wire pwd_ok = (pwdata[31:16] == pwd_ff[15:0]);
  wire any_byp = |byp_ff;
  wire [NCH-1:0] ch_onehot = {{(NCH-1){1'b0}}, 1'b1} << ch_ff;
  // test sequence
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE; // [R19]
      ch_ff <= {CW{1'b0}};
      auto_ff <= 1'b0;
      byp_ff <= {NCH{1'b0}};
      ftrip_ff <= {NCH{1'b0}};
      subt_ff <= 8'h00;
      step_ff <= 3'd0;
      cnt_ff <= 16'h0000;
      results_ff <= 8'h00;
      seq_err_ff <= 1'b0;
    end else if (!attached_s) begin
      // unit detached: drop any bypass and abandon the test [R13]
      state_ff <= S_IDLE;
      byp_ff <= {NCH{1'b0}};
      ftrip_ff <= {NCH{1'b0}};
      step_ff <= 3'd0;
      cnt_ff <= 16'h0000;
    end else begin
      if (test_wr && cmd == `PCB_CMD_ABORT) begin
        state_ff <= S_IDLE;
        byp_ff <= {NCH{1'b0}};
        ftrip_ff <= {NCH{1'b0}};
      end else begin
        case (state_ff)
          S_IDLE: begin
            if (test_wr && cmd == `PCB_CMD_SEL) begin // [R4]
              ch_ff <= cmd_ch;
              state_ff <= S_CHSEL;
            end else if (test_wr && cmd != `PCB_CMD_NONE) begin
              seq_err_ff <= 1'b1;
            end
          end
          S_CHSEL: begin
            if (test_wr && cmd == `PCB_CMD_MODE) begin // [R4]
              auto_ff <= pwdata[`PCB_TEST_AUTO_BIT];
              state_ff <= S_MODE;
            end else if (test_wr) begin
              seq_err_ff <= 1'b1;
            end
          end
          S_MODE: begin
            if (test_wr && cmd == `PCB_CMD_TRIP) begin
              ftrip_ff <= ftrip_ff | ch_onehot; // [R3]
              state_ff <= S_TRBY;
            end else if (test_wr && cmd == `PCB_CMD_BYP && pwd_ok && !any_byp) begin
              byp_ff <= ch_onehot; // only one channel bypassed at a time [R3] [R11]
              state_ff <= S_TRBY;
            end else if (test_wr) begin
              seq_err_ff <= 1'b1;
            end
          end
          S_TRBY: begin
            if (test_wr && cmd == `PCB_CMD_CALREF) begin
              state_ff <= S_CALREF; // [R4]
            end else if (test_wr) begin
              seq_err_ff <= 1'b1;
            end
          end
          S_CALREF: begin
            if (test_wr && cmd == `PCB_CMD_TBASE) begin
              state_ff <= S_TBASE; // [R4]
            end else if (test_wr) begin
              seq_err_ff <= 1'b1;
            end
          end
          S_TBASE: begin
            if (test_wr && cmd == `PCB_CMD_SUBT) begin
              subt_ff <= pwdata[31:24];
              state_ff <= S_SUBT; // [R4]
            end else if (test_wr) begin
              seq_err_ff <= 1'b1;
            end
          end
          S_SUBT: begin
            if (test_wr && cmd == `PCB_CMD_INJ) begin
              state_ff <= S_RUN; // [R4]
              step_ff <= 3'd0;
              cnt_ff <= 16'h0000;
              results_ff <= 8'h00;
            end else if (test_wr) begin
              seq_err_ff <= 1'b1;
            end
          end
          S_RUN: begin
            // steps advance on done pin or step time; skipped subtests take one cycle [R5]
            if (!subt_ff[step_ff] || done_s || cnt_ff == STEP_CYC - 16'h0001) begin
              results_ff[step_ff] <= subt_ff[step_ff];
              cnt_ff <= 16'h0000;
              if (step_ff == LAST_STEP) begin
                state_ff <= S_VERIFY;
              end else begin
                step_ff <= step_ff + 3'd1;
              end
            end else begin
              cnt_ff <= cnt_ff + 16'h0001;
            end
          end
          S_VERIFY: begin
            byp_ff <= {NCH{1'b0}}; // [R6]
            ftrip_ff <= {NCH{1'b0}};
            results_ff[7] <= 1'b1;
            state_ff <= S_REPORT;
          end
          S_REPORT: begin
            if (test_wr && cmd == `PCB_CMD_SEL) begin
              ch_ff <= cmd_ch;
              state_ff <= S_CHSEL;
            end
          end
          default: state_ff <= S_IDLE;
        endcase
      end
      if (wr && paddr == `PCB_OFF_STAT && pwdata[0]) begin
        seq_err_ff <= 1'b0;
      end
    end
  end
  // software registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pwd_ff <= `PCB_RST_PWD;
      fail_pref_ff <= RST_FAIL[NCH-1:0];
      refh_ff <= `PCB_RST_REFH;
      refl_ff <= `PCB_RST_REFL;
      coef_sel_ff <= {CW{1'b0}};
      cal_en_ff <= {NCH{1'b0}};
      cal_hi_ff <= 1'b0;
      fatal_seen_ff <= 1'b0;
      nonfatal_seen_ff <= 1'b0;
    end else begin
      if (wr && paddr == `PCB_OFF_PWD) pwd_ff <= pwdata;
      if (wr && paddr == `PCB_OFF_FAIL) fail_pref_ff <= pwdata[NCH-1:0];
      if (wr && paddr == `PCB_OFF_REFH) refh_ff <= pwdata[15:0];
      if (wr && paddr == `PCB_OFF_REFL) refl_ff <= pwdata[15:0];
      if (wr && paddr == `PCB_OFF_COEF) coef_sel_ff <= pwdata[CW-1:0];
      if (wr && paddr == `PCB_OFF_CAL) begin
        cal_en_ff <= pwdata[NCH-1:0];
        cal_hi_ff <= pwdata[8];
      end
      // sticky diagnostics: a new detection wins over the clear
      fatal_seen_ff <= fatal_s | (fatal_seen_ff & ~(wr && paddr == `PCB_OFF_DIAG && pwdata[0]));
      nonfatal_seen_ff <= nonfatal_s | (nonfatal_seen_ff & ~(wr && paddr == `PCB_OFF_DIAG && pwdata[1]));
    end
  end
  // outputs to plant
  integer k;
  reg [NCH-1:0] nxt_relay;
  always @* begin
    for (k = 0; k < NCH; k = k + 1) begin
      if (!power_s || fatal_s) begin
        nxt_relay[k] = !fail_pref_ff[k]; // [R14] [R15]
      end else if (ftrip_ff[k]) begin
        nxt_relay[k] = 1'b0; // [R2]
      end else if (byp_ff[k]) begin
        nxt_relay[k] = 1'b1; // [R1]
      end else begin
        nxt_relay[k] = !cmp_s[k];
      end
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      relay_energised <= {NCH{1'b0}};
      panel_light <= {NCH{1'b0}};
      chan_trip_alarm <= 1'b0;
      chan_status <= 1'b0;
      bypass_ind <= 1'b0;
      set_fail_contact <= 1'b0;
      trouble_contact <= 1'b0;
      aout <= AOUT_LOW;
      mux_sel_ref <= {NCH{1'b0}};
      mux_ref_hi <= {NCH{1'b0}};
      inject_en <= 1'b0;
      tester_step <= 3'd0;
    end else begin
      relay_energised <= nxt_relay;
      panel_light <= ~nxt_relay; // [R8]
      chan_trip_alarm <= |(~nxt_relay); // [R7]
      chan_status <= |(ftrip_ff | ~nxt_relay); // [R7]
      bypass_ind <= any_byp; // [R12]
      set_fail_contact <= fatal_s | nonfatal_s; // [R17] [R18]
      trouble_contact <= nonfatal_s; // [R18]
      if (!power_s) begin
        aout <= AOUT_LOW; // [R14]
      end else if (!fatal_s) begin
        aout <= aout_in; // fatal holds the last value [R16]
      end
      mux_sel_ref <= cal_en_ff; // [R9]
      mux_ref_hi <= {NCH{cal_hi_ff}};
      inject_en <= (state_ff == S_RUN); // [R5]
      tester_step <= step_ff;
    end
  end
  // apb read data
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `PCB_OFF_CTRL: prdata <= {{(32-NCH){1'b0}}, fail_pref_ff};
        `PCB_OFF_TEST: prdata <= {15'h0000, auto_ff, {(8-CW){1'b0}}, ch_ff, 4'h0, state_ff};
        `PCB_OFF_STEP: prdata <= {16'h0000, results_ff, subt_ff[4:0], step_ff};
        `PCB_OFF_CMP: prdata <= {{(32-2*NCH){1'b0}}, byp_ff, ftrip_ff};
        `PCB_OFF_STAT: prdata <= {27'h0000000, attached_s, power_s, any_byp, inject_en, seq_err_ff};
        `PCB_OFF_DIAG: prdata <= {30'h00000000, nonfatal_seen_ff, fatal_seen_ff};
        `PCB_OFF_PWD: prdata <= 32'h0000_0000;
        `PCB_OFF_FAIL: prdata <= {{(32-NCH){1'b0}}, fail_pref_ff};
        `PCB_OFF_AOUT: prdata <= {16'h0000, aout};
        `PCB_OFF_CAL: prdata <= {23'h000000, cal_hi_ff, {(8-NCH){1'b0}}, cal_en_ff};
        `PCB_OFF_REFH: prdata <= {16'h0000, refh_ff};
        `PCB_OFF_REFL: prdata <= {16'h0000, refl_ff};
        `PCB_OFF_COEF: prdata <= coef_q;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  wire unused_rd = rd;
endmodule // pcb_top
`default_nettype wire

// ==== tb_protection_channel_test_bypass.sv ====
// self-checking bench for the channel set control block
`timescale 1ns/1ns
`default_nettype none
`include "pcb_defs.vh"
module tb_protection_channel_test_bypass;
  typedef struct {logic [11:0] a; logic [31:0] v;} pcb_row_t;
  pcb_row_t rows [6];
  logic clk, rst, psel, penable, pwrite, pready, pslverr, attached, power_ok, fatal, nonfatal;
  logic step_done, rd_valid, rd_hi, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] cmp_trip_in, relay, light, sel_ref, ref_hi;
  logic [1:0] rd_ch;
  logic [15:0] rd_data, aout_in, aout;
  logic alarm, status, byp_ind, fail_c, trouble_c, inject_en, err;
  logic [2:0] step;
  int fails, n_compared, cyc, i;
  pcb_top pcb_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_trip_in(cmp_trip_in), .test_unit_attached(attached), .power_ok(power_ok),
    .diag_fatal(fatal), .diag_nonfatal(nonfatal), .step_done(step_done), .rd_valid(rd_valid),
    .rd_ch(rd_ch), .rd_hi(rd_hi), .rd_data(rd_data), .aout_in(aout_in), .relay_energised(relay),
    .panel_light(light), .chan_trip_alarm(alarm), .chan_status(status), .bypass_ind(byp_ind),
    .set_fail_contact(fail_c), .trouble_contact(trouble_c), .aout(aout), .mux_sel_ref(sel_ref),
    .mux_ref_hi(ref_hi), .inject_en(inject_en), .tester_step(step));
  pcb_partner pcb_partner_i (.clk(clk), .rst(rst), .tester_step(step), .mux_sel_ref(sel_ref),
    .mux_ref_hi(ref_hi), .slow(slow), .step_done(step_done), .rd_valid(rd_valid), .rd_ch(rd_ch),
    .rd_hi(rd_hi), .rd_data(rd_data));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [31:0] d);
    apb(1'b1, `PCB_OFF_TEST, d);
  endtask
  // runs the rest of the start order and waits for the verify flag
  task automatic finish_run(input logic [4:0] mask);
    cmd(32'h0000_0005);
    cmd(32'h0000_0006);
    cmd({3'h0, mask, 24'h000007});
    cmd(32'h0000_0008);
    wclk(3);
    check("inject_en", inject_en, 1);
    rd = 0;
    for (i = 0; i < 100 && rd[15] !== 1'b1; i++) apb(1'b0, `PCB_OFF_STEP, 0);
    check("verify", rd[15], 1);
    check("results", {rd[15:8], rd[7:3], rd[2:0]}, {3'b100, mask, mask, 3'd4});
    apb(1'b0, `PCB_OFF_CMP, 0);
    check("modes", rd, 0);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize;
    end
  end
  initial begin
    rows = '{'{`PCB_OFF_PWD, 32'h0}, '{`PCB_OFF_FAIL, 32'h0}, '{`PCB_OFF_REFH, 32'hc000},
      '{`PCB_OFF_REFL, 32'h4000}, '{`PCB_OFF_COEF, 32'h4000_0000}, '{`PCB_OFF_CMP, 32'h0}};
    rst = 1'b1;
    {psel, penable, pwrite, attached, fatal, nonfatal, slow} = '0;
    {paddr, pwdata, cmp_trip_in} = '0;
    power_ok = 1'b1;
    aout_in = 16'h1234;
    wclk(5);
    rst <= 1'b0;
    foreach (rows[k]) begin
      apb(1'b0, rows[k].a, 0);
      check("reset value", rd, rows[k].v);
    end
    apb(1'b0, 12'h040, 0);
    check("slverr", err, 1);
    attached <= 1'b1;
    cmp_trip_in <= 4'h2;
    apb(1'b1, `PCB_OFF_PWD, 32'h0000_1234);
    cmd(32'h0000_0101);
    cmd(32'h0001_0002);
    cmd(32'h0000_0008);
    apb(1'b0, `PCB_OFF_STAT, 0);
    check("seq error", rd[0], 1);
    apb(1'b1, `PCB_OFF_STAT, 1);
    cmd(32'h5555_0004);
    apb(1'b0, `PCB_OFF_CMP, 0);
    check("bad password", rd, 0);
    cmd(32'h1234_0004);
    apb(1'b0, `PCB_OFF_CMP, 0);
    check("bypass", rd, 32'h20);
    wclk(3);
    check("bypass_ind", byp_ind, 1);
    check("relays", relay, 4'hf);
    finish_run(5'h1f);
    check("bypass_ind", byp_ind, 0);
    cmd(32'h0000_0201);
    cmd(32'h0000_0002);
    cmd(32'h0000_0003);
    wclk(3);
    check("forced relay", relay[2], 0);
    check("alarm", alarm, 1);
    check("status", status, 1);
    slow <= 1'b1;
    finish_run(5'h01);
    check("relays", relay, 4'hd);
    cmd(32'h0000_0001);
    cmd(32'h0000_0002);
    cmd(32'h1234_0004);
    wclk(3);
    check("bypass_ind", byp_ind, 1);
    attached <= 1'b0;
    wclk(6);
    check("bypass_ind", byp_ind, 0);
    attached <= 1'b1;
    wclk(6);
    apb(1'b0, `PCB_OFF_CMP, 0);
    check("detach", rd, 0);
    apb(1'b1, `PCB_OFF_CAL, 32'h0000_0101);
    wclk(3);
    check("ref mux", {sel_ref[0], ref_hi[0]}, 2'b11);
    wclk(40);
    apb(1'b1, `PCB_OFF_COEF, 0);
    apb(1'b0, `PCB_OFF_COEF, 0);
    check("gain trim", {rd[31:16] < 16'h4000, rd[15:0]}, {1'b1, 16'h0000});
    apb(1'b1, `PCB_OFF_CAL, 32'h0000_0001);
    wclk(40);
    apb(1'b0, `PCB_OFF_COEF, 0);
    check("offset trim", rd[15:12], 4'hf);
    apb(1'b1, `PCB_OFF_CAL, 0);
    cmp_trip_in <= 4'h0;
    apb(1'b1, `PCB_OFF_FAIL, 32'h5);
    power_ok <= 1'b0;
    wclk(6);
    check("power relays", relay, 4'ha);
    check("power aout", aout, 0);
    power_ok <= 1'b1;
    wclk(6);
    fatal <= 1'b1;
    wclk(6);
    aout_in <= 16'h0bad;
    wclk(4);
    check("fatal aout", aout, 16'h1234);
    check("fatal relays", relay, 4'ha);
    check("fail contact", fail_c, 1);
    apb(1'b0, `PCB_OFF_DIAG, 0);
    check("diag sticky", rd[1:0], 2'b01);
    fatal <= 1'b0;
    wclk(5);
    apb(1'b1, `PCB_OFF_DIAG, 32'h3);
    apb(1'b0, `PCB_OFF_DIAG, 0);
    check("diag clear", rd[1:0], 2'b00);
    nonfatal <= 1'b1;
    wclk(6);
    check("nonfatal relays", relay, 4'hf);
    check("nonfatal aout", aout, 16'h0bad);
    check("trouble", trouble_c, 1);
    check("nonfatal contact", fail_c, 1);
    summarize;
  end
endmodule // tb_protection_channel_test_bypass
`default_nettype wire
